// [pkg/flash_pwr_pkg.sv]
/*
 Shared constants for the flash power-state and reset control link:
 instruction codes, shift widths and timing counts at the core clock rate.
 Assumes a 100 MHz core clock on both ends of the serial link.
*/
package flash_pwr_pkg;
    localparam int unsigned CNT_W = 12;
    localparam logic [7:0] SIG_READ_CMD = 8'hAB;
    localparam logic [7:0] WAKE_CMD_DEF = 8'hA5;
    localparam logic [7:0] ARM_CMD_DEF = 8'h3C;
    localparam logic [7:0] FIRE_CMD_DEF = 8'hC3;
    // Arbitrary signature value
    localparam logic [7:0] SIGNATURE_DEF = 8'h5A;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] SIG_FIRST_BIT = 8'h09;
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned WAKE_DELAY_NS = 8800;
    localparam int unsigned WAKE_SIG_DELAY_NS = 8800;
    localparam int unsigned REC_PROGRAM_NS = 2000;
    localparam int unsigned REC_OTHER_NS = 500;
    localparam int unsigned POWER_UP_SELECT_NS = 10000;
    localparam int unsigned DESELECT_NS = 40;
    // Longest times round down, least times round up
    localparam logic [11:0] WAKE_CYC = 12'(WAKE_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [11:0] WAKE_SIG_CYC = 12'(WAKE_SIG_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [11:0] REC_PROGRAM_CYC = 12'(REC_PROGRAM_NS / CLK_PERIOD_NS);
    localparam logic [11:0] REC_OTHER_CYC = 12'(REC_OTHER_NS / CLK_PERIOD_NS);
    localparam logic [11:0] POWER_UP_CYC =
        12'((POWER_UP_SELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] DESELECT_CYC =
        12'((DESELECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // Covers both synchroniser paths between host and device
    localparam logic [11:0] SYNC_MARGIN_CYC = 12'h008;
    localparam logic [3:0] SCLK_HALF_DIV = 4'h8;
endpackage

// [pkg/flash_link_if.sv]
/*
 Serial link between the host controller and the flash power-state block.
 Assumes the host reads data out as high while its enable is low.
*/
`timescale 1ns/1ps
interface flash_link_if;
    logic cs_n;
    logic sclk;
    logic si;
    logic so;
    logic so_oe;
    logic [1:0] spare;
    modport dev (input cs_n, input sclk, input si, input spare, output so, output so_oe);
    modport host (output cs_n, output sclk, output si, output spare, input so, input so_oe);
endinterface

// [core/link_sync.sv]
/*
 Per-bit three-flop synchroniser with agreement filter and edge pulses.
 Assumes inputs are asynchronous to clk; pulses lead the level by one edge.
*/
`timescale 1ns/1ps
module link_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    generate
        if (W < 1) begin : g_bad_width
            $error("link_sync needs at least one bit");
        end
        for (genvar i = 0; i < W; i++) begin : g_bit
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            wire logic agree = s2_reg == s3_reg;
            always_ff @(posedge clk) begin
                if (rst) begin
                    s1_reg <= INIT[i];
                    s2_reg <= INIT[i];
                    s3_reg <= INIT[i];
                    lvl_reg <= INIT[i];
                end else begin
                    s1_reg <= din[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    // Only a settled value moves the level
                    if (agree) begin
                        lvl_reg <= s2_reg;
                    end
                end
            end
            assign level[i] = lvl_reg;
            assign rise[i] = agree && s2_reg && !lvl_reg;
            assign fall[i] = agree && !s2_reg && lvl_reg;
        end
    endgenerate
endmodule // link_sync

// [core/flash_power_state_reset_ctl.sv]
/*
 Device end: serial command capture, wake from deep power-down, signature
 readout and two-step software reset. Assumes the host keeps chip select
 high for the wake and recovery times, and that por_active comes from a
 supply monitor already timed to clk.
*/
`timescale 1ns/1ps
// Functional notes
// - Wake finishes at select rise, standby follows
// - Wake outside deep power-down: immediate standby
// - Wake from deep power-down waits wake delay
// - Signature command shifts out eight-bit signature
// - Signature byte repeats while host keeps clocking
// - Signature ends after one full byte, then delay
// - Wake and signature leave running cycles alone
// - Spare data pins ignored during these commands
// - Signature command code is hexadecimal AB
// - Arm then fire resets volatile state to standby
// - Any other command after arm disarms, except one given in deep power-down
// - Fire during program or erase aborts it
// - Recovery after interrupted program takes longer
// - Power-up lands in standby, latch cleared
// - Host waits select delay after power-up
// - Power-on reset holds logic, ignores commands
// - Both wake delays at most 8.8 us
module flash_power_state_reset_ctl #(
    parameter logic [7:0] WAKE_CMD = flash_pwr_pkg::WAKE_CMD_DEF,
    parameter logic [7:0] ARM_CMD = flash_pwr_pkg::ARM_CMD_DEF,
    parameter logic [7:0] FIRE_CMD = flash_pwr_pkg::FIRE_CMD_DEF,
    // Arbitrary signature value
    parameter logic [7:0] SIGNATURE = flash_pwr_pkg::SIGNATURE_DEF,
    parameter logic [11:0] WAKE_CYC = flash_pwr_pkg::WAKE_CYC,
    parameter logic [11:0] WAKE_SIG_CYC = flash_pwr_pkg::WAKE_SIG_CYC,
    parameter logic [11:0] REC_PROG_CYC = flash_pwr_pkg::REC_PROGRAM_CYC,
    parameter logic [11:0] REC_OTHER_CYC = flash_pwr_pkg::REC_OTHER_CYC
) (
    input wire logic clk,
    input wire logic rst,
    flash_link_if.dev link,
    input wire logic por_active,
    input wire logic deep_entry_req,
    input wire logic wel_set,
    input wire logic op_busy,
    input wire logic op_is_program,
    output logic in_standby,
    output logic in_deep_power_down,
    output logic waking,
    output logic in_recovery,
    output logic write_enable_latch,
    output logic soft_reset_pulse,
    output logic op_abort_pulse,
    output logic reset_armed
);
    typedef enum logic [1:0] {PWR_STANDBY, PWR_DEEP, PWR_WAKING, PWR_RECOVER} pwr_state_t;

    generate
        if (WAKE_CMD == ARM_CMD || WAKE_CMD == FIRE_CMD || ARM_CMD == FIRE_CMD ||
            WAKE_CMD == flash_pwr_pkg::SIG_READ_CMD ||
            ARM_CMD == flash_pwr_pkg::SIG_READ_CMD ||
            FIRE_CMD == flash_pwr_pkg::SIG_READ_CMD) begin : g_bad_codes
            $error("Instruction codes must all differ");
        end
        if (WAKE_CYC == 12'h000 || WAKE_SIG_CYC == 12'h000 || REC_OTHER_CYC == 12'h000 ||
            REC_PROG_CYC <= REC_OTHER_CYC) begin : g_bad_times
            $error("Delay counts must be nonzero, program recovery longest");
        end
    endgenerate

    pwr_state_t pwr_state_reg;
    pwr_state_t pwr_state_next;
    logic [11:0] delay_cnt_reg;
    logic [11:0] delay_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [3:0] bit_cnt_reg;
    logic [3:0] sig_cnt_reg;
    logic [2:0] sig_idx_reg;
    logic op_valid_reg;
    logic extra_reg;
    logic sig_mode_reg;
    logic so_reg;
    logic so_oe_reg;
    logic arm_reg;
    logic wel_reg;
    logic soft_reset_reg;
    logic abort_reg;
    logic [2:0] pin_level;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    // Spare data pins are deliberately not sampled at all
    link_sync #(.W(3), .INIT(3'h4)) u_pins (
        .clk(clk),
        .rst(rst),
        .din({link.cs_n, link.sclk, link.si}),
        .level(pin_level),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    wire logic core_rst = rst || por_active;
    wire logic cs_n_s = pin_level[2];
    wire logic cs_rise = pin_rise[2];
    wire logic cs_fall = pin_fall[2];
    wire logic sclk_rise = pin_rise[1];
    wire logic sclk_fall = pin_fall[1];
    wire logic si_s = pin_level[0];
    wire logic is_deep = pwr_state_reg == PWR_DEEP;
    // Waking and recovering ignore the link entirely
    wire logic accepting = pwr_state_reg == PWR_STANDBY || is_deep;
    wire logic bit_in = sclk_rise && !cs_n_s && accepting;
    wire logic first_byte = bit_cnt_reg != flash_pwr_pkg::BYTE_BITS;
    wire logic byte_done = bit_in && bit_cnt_reg == 4'h7;
    wire logic [7:0] code_next = {shift_reg[6:0], si_s};
    wire logic frame_end = cs_rise && op_valid_reg && accepting;
    wire logic hit_wake = frame_end && opcode_reg == WAKE_CMD;
    wire logic hit_sig = frame_end && opcode_reg == flash_pwr_pkg::SIG_READ_CMD &&
        sig_cnt_reg == flash_pwr_pkg::BYTE_BITS;
    wire logic wake_go = hit_wake || hit_sig;
    // In deep power-down only wake and signature are decoded
    wire logic std_cmd = frame_end && !is_deep && !extra_reg;
    wire logic hit_arm = std_cmd && opcode_reg == ARM_CMD;
    wire logic hit_fire = std_cmd && opcode_reg == FIRE_CMD && arm_reg;
    wire logic prog_cut = op_busy && op_is_program;
    // Wake and signature drive nothing toward the program engine
    wire logic deep_go = deep_entry_req && cs_n_s && !wake_go;

    always_comb begin
        pwr_state_next = pwr_state_reg;
        delay_cnt_next = delay_cnt_reg;
        case (pwr_state_reg)
            PWR_STANDBY: begin
                if (hit_fire) begin
                    pwr_state_next = PWR_RECOVER;
                    delay_cnt_next = prog_cut ? REC_PROG_CYC : REC_OTHER_CYC;
                end else if (deep_go) begin
                    pwr_state_next = PWR_DEEP;
                end
                // A wake seen here keeps standby with no delay
            end
            PWR_DEEP: begin
                if (wake_go) begin
                    pwr_state_next = PWR_WAKING;
                    delay_cnt_next = hit_sig ? WAKE_SIG_CYC : WAKE_CYC;
                end
            end
            PWR_WAKING, PWR_RECOVER: begin
                if (delay_cnt_reg <= 12'h001) begin
                    pwr_state_next = PWR_STANDBY;
                end else begin
                    delay_cnt_next = delay_cnt_reg - 12'h001;
                end
            end
            default: begin
                pwr_state_next = PWR_STANDBY;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            pwr_state_reg <= PWR_STANDBY;
            delay_cnt_reg <= 12'h000;
        end else begin
            pwr_state_reg <= pwr_state_next;
            delay_cnt_reg <= delay_cnt_next;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst || cs_fall) begin
            bit_cnt_reg <= 4'h0;
            extra_reg <= 1'b0;
        end else if (bit_in) begin
            if (first_byte) begin
                shift_reg <= code_next;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else begin
                extra_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst || cs_fall) begin
            op_valid_reg <= 1'b0;
            sig_mode_reg <= 1'b0;
        end else if (byte_done) begin
            opcode_reg <= code_next;
            op_valid_reg <= 1'b1;
            sig_mode_reg <= code_next == flash_pwr_pkg::SIG_READ_CMD;
        end
    end

    // Counts host samples of the signature; saturates once one byte is out
    always_ff @(posedge clk) begin
        if (core_rst || cs_fall) begin
            sig_cnt_reg <= 4'h0;
        end else if (bit_in && !first_byte && sig_mode_reg &&
                     sig_cnt_reg != flash_pwr_pkg::BYTE_BITS) begin
            sig_cnt_reg <= sig_cnt_reg + 4'h1;
        end
    end

    // Bits change on falling clock so the host can sample on the next one
    always_ff @(posedge clk) begin
        if (core_rst || cs_fall) begin
            sig_idx_reg <= 3'h0;
            so_reg <= 1'b0;
        end else if (sclk_fall && sig_mode_reg && !cs_n_s) begin
            so_reg <= SIGNATURE[~sig_idx_reg];
            sig_idx_reg <= sig_idx_reg + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst || cs_rise) begin
            so_oe_reg <= 1'b0;
        end else if (sclk_fall && sig_mode_reg && !cs_n_s) begin
            so_oe_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst || soft_reset_reg) begin
            arm_reg <= 1'b0;
        end else if (frame_end && !is_deep) begin
            arm_reg <= hit_arm;
        end
    end

    // A set in the reset cycle wins; the latch is volatile otherwise
    always_ff @(posedge clk) begin
        if (core_rst) begin
            wel_reg <= 1'b0;
        end else if (wel_set && pwr_state_reg == PWR_STANDBY) begin
            wel_reg <= 1'b1;
        end else if (hit_fire) begin
            wel_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (core_rst) begin
            soft_reset_reg <= 1'b0;
            abort_reg <= 1'b0;
        end else begin
            soft_reset_reg <= hit_fire;
            abort_reg <= hit_fire && op_busy;
        end
    end

    assign link.so = so_reg;
    assign link.so_oe = so_oe_reg;
    assign in_standby = pwr_state_reg == PWR_STANDBY;
    assign in_deep_power_down = is_deep;
    assign waking = pwr_state_reg == PWR_WAKING;
    assign in_recovery = pwr_state_reg == PWR_RECOVER;
    assign write_enable_latch = wel_reg;
    assign soft_reset_pulse = soft_reset_reg;
    assign op_abort_pulse = abort_reg;
    assign reset_armed = arm_reg;
endmodule // flash_power_state_reset_ctl

// [core/flash_host_ctl.sv]
/*
 Host end: issues one instruction per request on the serial link, reads
 back bytes, then holds chip select high for the guard time the command
 needs. Assumes the device answers within half a serial clock period.
*/
`timescale 1ns/1ps
module flash_host_ctl #(
    parameter logic [7:0] WAKE_CMD = flash_pwr_pkg::WAKE_CMD_DEF,
    parameter logic [7:0] FIRE_CMD = flash_pwr_pkg::FIRE_CMD_DEF,
    parameter logic [3:0] HALF_DIV = flash_pwr_pkg::SCLK_HALF_DIV,
    parameter logic [11:0] PWRUP_CYC = flash_pwr_pkg::POWER_UP_CYC,
    parameter logic [11:0] WAKE_GUARD =
        flash_pwr_pkg::WAKE_CYC + flash_pwr_pkg::SYNC_MARGIN_CYC,
    parameter logic [11:0] REC_GUARD =
        flash_pwr_pkg::REC_PROGRAM_CYC + flash_pwr_pkg::SYNC_MARGIN_CYC,
    parameter logic [11:0] DESEL_CYC =
        flash_pwr_pkg::DESELECT_CYC + flash_pwr_pkg::SYNC_MARGIN_CYC
) (
    input wire logic clk,
    input wire logic rst,
    flash_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_code,
    input wire logic [3:0] cmd_read_bytes,
    output logic cmd_ready,
    output logic [7:0] rsp_data,
    output logic rsp_valid,
    output logic cmd_done,
    output logic link_ready
);
    typedef enum logic [1:0] {H_POWERUP, H_IDLE, H_SHIFT, H_GUARD} host_state_t;

    generate
        if (HALF_DIV < 4'h4 || PWRUP_CYC == 12'h000 || DESEL_CYC == 12'h000) begin : g_bad
            $error("Half period below four cycles or zero delay");
        end
    endgenerate

    host_state_t state_reg;
    logic [11:0] cnt_reg;
    logic [3:0] div_reg;
    logic [7:0] rises_reg;
    logic [7:0] total_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] code_reg;
    logic [7:0] rsp_reg;
    logic cs_n_reg;
    logic sclk_reg;
    logic si_reg;
    logic rsp_valid_reg;
    logic done_reg;
    logic so_s;

    // A released data line reads as pulled high, never as its last driven bit
    wire logic so_pin = link.so_oe ? link.so : 1'b1;

    link_sync #(.W(1), .INIT(1'b1)) u_so (
        .clk(clk),
        .rst(rst),
        .din(so_pin),
        .level(so_s),
        .rise(),
        .fall()
    );

    wire logic tick = div_reg == HALF_DIV - 4'h1;
    wire logic start = state_reg == H_IDLE && cmd_valid;
    wire logic is_sig = cmd_code == flash_pwr_pkg::SIG_READ_CMD;
    // A signature read always takes at least one full byte
    wire logic [3:0] bytes_eff = (is_sig && cmd_read_bytes == 4'h0) ? 4'h1 : cmd_read_bytes;
    wire logic [7:0] total_next = {1'b0, bytes_eff, 3'h0} + 8'h08;
    wire logic rise_now = state_reg == H_SHIFT && tick && !sclk_reg;
    wire logic fall_now = state_reg == H_SHIFT && tick && sclk_reg;
    wire logic sample = fall_now && rises_reg >= flash_pwr_pkg::SIG_FIRST_BIT;
    wire logic [7:0] rx_next = {rx_reg[6:0], so_s};
    wire logic byte_out = sample && rises_reg[2:0] == 3'h0;
    wire logic last_fall = fall_now && rises_reg == total_reg;
    wire logic guard_wake = code_reg == WAKE_CMD || code_reg == flash_pwr_pkg::SIG_READ_CMD;
    wire logic [11:0] guard_cyc = guard_wake ? WAKE_GUARD :
        (code_reg == FIRE_CMD ? REC_GUARD : DESEL_CYC);
    wire logic cnt_end = cnt_reg <= 12'h001;

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= H_POWERUP;
            cnt_reg <= PWRUP_CYC;
        end else begin
            case (state_reg)
                H_POWERUP, H_GUARD: begin
                    cnt_reg <= cnt_reg - 12'h001;
                    if (cnt_end) begin
                        state_reg <= H_IDLE;
                    end
                end
                H_IDLE: begin
                    if (start) begin
                        state_reg <= H_SHIFT;
                    end
                end
                H_SHIFT: begin
                    if (last_fall) begin
                        state_reg <= H_GUARD;
                        cnt_reg <= guard_cyc;
                    end
                end
                default: begin
                    state_reg <= H_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst || start || tick) begin
            div_reg <= 4'h0;
        end else begin
            div_reg <= div_reg + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_n_reg <= 1'b1;
            sclk_reg <= 1'b0;
            si_reg <= 1'b0;
        end else if (start) begin
            cs_n_reg <= 1'b0;
            si_reg <= cmd_code[7];
            tx_reg <= {cmd_code[6:0], 1'b0};
            code_reg <= cmd_code;
            total_reg <= total_next;
            rises_reg <= 8'h00;
        end else if (rise_now) begin
            sclk_reg <= 1'b1;
            rises_reg <= rises_reg + 8'h01;
        end else if (fall_now) begin
            sclk_reg <= 1'b0;
            si_reg <= tx_reg[7];
            tx_reg <= {tx_reg[6:0], 1'b0};
            cs_n_reg <= last_fall;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rsp_valid_reg <= 1'b0;
            done_reg <= 1'b0;
            rsp_reg <= 8'h00;
        end else begin
            rsp_valid_reg <= byte_out;
            done_reg <= state_reg == H_GUARD && cnt_end;
            if (sample) begin
                rx_reg <= rx_next;
            end
            if (byte_out) begin
                rsp_reg <= rx_next;
            end
        end
    end

    assign link.cs_n = cs_n_reg;
    assign link.sclk = sclk_reg;
    assign link.si = si_reg;
    assign link.spare = 2'h0;
    assign cmd_ready = state_reg == H_IDLE;
    assign link_ready = state_reg != H_POWERUP;
    assign rsp_data = rsp_reg;
    assign rsp_valid = rsp_valid_reg;
    assign cmd_done = done_reg;
endmodule // flash_host_ctl

// [testbench/flash_link_asserts.sv]
/*
 Checker of the device state outputs and the select and data-out lines.
 Assumes shortened counts: wake 20 cycles, recovery 10 and 5 cycles.
*/
`timescale 1ns/1ps
module flash_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic so_oe,
    input wire logic por_active,
    input wire logic in_standby,
    input wire logic in_deep_power_down,
    input wire logic waking,
    input wire logic in_recovery,
    input wire logic write_enable_latch,
    input wire logic reset_armed,
    input wire logic soft_reset_pulse,
    input wire logic op_abort_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    property p_oe_idle; cs_n [*8] |-> !so_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data out driven while idle");
    property p_por; por_active |=> in_standby && !write_enable_latch && !reset_armed; endproperty
    a_por: assert property (p_por) else $error("power-on reset not holding state");
    property p_pulse; soft_reset_pulse |=> !soft_reset_pulse; endproperty
    a_pulse: assert property (p_pulse) else $error("soft reset pulse too long");
    property p_abort; op_abort_pulse |-> soft_reset_pulse; endproperty
    a_abort: assert property (p_abort) else $error("abort without soft reset");
    property p_disarm; soft_reset_pulse |=> !reset_armed; endproperty
    a_disarm: assert property (p_disarm) else $error("arm kept after reset");
    property p_rec_len; $rose(in_recovery) |-> in_recovery [*5] ##[0:6] !in_recovery; endproperty
    a_rec_len: assert property (p_rec_len) else $error("recovery length wrong");
    property p_wake_len; $rose(waking) |-> waking [*8] ##[12:14] in_standby; endproperty
    a_wake_len: assert property (p_wake_len) else $error("wake delay wrong");
    property p_wake_src; $rose(waking) |-> $past(in_deep_power_down); endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake delay outside power-down");
    property p_rec_entry; $rose(in_recovery) |-> ##[0:2] soft_reset_pulse; endproperty
    a_rec_entry: assert property (p_rec_entry) else $error("recovery without reset");
endmodule // flash_link_asserts

// [testbench/flash_power_state_reset_ctl_tb_top.sv]
/*
 Bench joining host and device ends over the serial link.
 Assumes shortened wake and recovery counts and a 160 ns serial clock.
*/
`timescale 1ns/1ps
module flash_power_state_reset_ctl_tb_top;
    logic clk = 0, rst = 1, por_active = 0, deep_entry_req = 0, wel_set = 0;
    logic op_busy = 0, op_is_program = 0, cmd_valid = 0;
    logic [7:0] cmd_code = 8'h00;
    logic [3:0] cmd_read_bytes = 4'h0;
    logic in_standby, in_deep_power_down, waking, in_recovery, write_enable_latch;
    logic soft_reset_pulse, op_abort_pulse, reset_armed, cmd_ready, rsp_valid, cmd_done;
    logic [7:0] rsp_data;
    logic link_ready;
    logic [11:0] nb, bad, wc, rc, sc, ac;
    int fail_count = 0, checks_done = 0, cyc = 0;
    typedef struct {logic [7:0] code; logic [3:0] n; logic arm; logic [11:0] rec;} row_t;
    // Fire without a live arm must do nothing, so rows 4 and 6 differ
    row_t rows [7] = '{'{8'hAB, 4'h1, 1'b0, 12'h000}, '{8'hAB, 4'h3, 1'b0, 12'h000},
        '{8'h3C, 4'h0, 1'b1, 12'h000}, '{8'hA5, 4'h0, 1'b0, 12'h000},
        '{8'hC3, 4'h0, 1'b0, 12'h000}, '{8'h3C, 4'h0, 1'b1, 12'h000},
        '{8'hC3, 4'h0, 1'b0, 12'h005}};
    flash_link_if lk();
    always #5 clk = ~clk;
    flash_power_state_reset_ctl #(.WAKE_CYC(12'h014), .WAKE_SIG_CYC(12'h014),
        .REC_PROG_CYC(12'h00A), .REC_OTHER_CYC(12'h005)) i_flash_power_state_reset_ctl (
        .clk, .rst, .link(lk.dev), .por_active, .deep_entry_req, .wel_set, .op_busy,
        .op_is_program, .in_standby, .in_deep_power_down, .waking, .in_recovery,
        .write_enable_latch, .soft_reset_pulse, .op_abort_pulse, .reset_armed);
    // Power-up wait and recovery guard keep their full counts; only the wake guard is cut
    flash_host_ctl #(.WAKE_GUARD(12'h01C))
        i_flash_host_ctl (.clk, .rst, .link(lk.host), .cmd_valid, .cmd_code,
        .cmd_read_bytes, .cmd_ready, .rsp_data, .rsp_valid, .cmd_done, .link_ready);
    flash_link_asserts i_flash_link_asserts (.clk, .rst, .cs_n(lk.cs_n), .so_oe(lk.so_oe),
        .por_active, .in_standby, .in_deep_power_down, .waking, .in_recovery,
        .write_enable_latch, .reset_armed, .soft_reset_pulse, .op_abort_pulse);

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk_bit(input logic g, input logic e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: flag %b expected %b", $time, g, e);
        end
    endtask

    task automatic chk_num(input logic [11:0] g, input logic [11:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("Error at %0t: count %0h expected %0h", $time, g, e);
        end
    endtask

    // Counts are taken on edges, so each pulse or state cycle counts once
    task automatic send(input logic [7:0] c, input logic [3:0] n);
        @(posedge clk);
        while (cmd_ready !== 1'b1) @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        cmd_read_bytes <= n;
        {nb, bad, wc, rc, sc, ac} = '0;
        @(posedge clk);
        cmd_valid <= 1'b0;
        while (cmd_done !== 1'b1) begin
            @(posedge clk);
            if (rsp_valid === 1'b1) begin
                nb++;
                bad += 12'(rsp_data !== flash_pwr_pkg::SIGNATURE_DEF);
            end
            wc += 12'(waking === 1'b1);
            rc += 12'(in_recovery === 1'b1);
            sc += 12'(soft_reset_pulse === 1'b1);
            ac += 12'(op_abort_pulse === 1'b1);
        end
    endtask

    task automatic poke(input logic d);
        @(posedge clk);
        deep_entry_req <= d;
        wel_set <= !d;
        @(posedge clk);
        deep_entry_req <= 1'b0;
        wel_set <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(in_standby, 1'b1);
        chk_bit(in_deep_power_down, 1'b0);
        chk_bit(write_enable_latch, 1'b0);
        chk_bit(link_ready, 1'b0);
        foreach (rows[i]) begin
            send(rows[i].code, rows[i].n);
            chk_num(nb, {8'h00, rows[i].n});
            chk_num(bad, 12'h000);
            chk_num(wc, 12'h000);
            chk_num(rc, rows[i].rec);
            chk_bit(reset_armed, rows[i].arm);
            chk_bit(in_standby, 1'b1);
            $display("row %0d done", i);
        end
        chk_bit(link_ready, 1'b1);
        poke(1'b0);
        chk_bit(write_enable_latch, 1'b1);
        op_busy <= 1'b1;
        op_is_program <= 1'b1;
        send(8'h3C, 4'h0);
        send(8'hC3, 4'h0);
        chk_num(rc, 12'h00A);
        chk_num(sc, 12'h001);
        chk_num(ac, 12'h001);
        chk_bit(write_enable_latch, 1'b0);
        op_is_program <= 1'b0;
        send(8'h3C, 4'h0);
        send(8'hC3, 4'h0);
        chk_num(rc, 12'h005);
        chk_num(ac, 12'h001);
        $display("reset during program done");
        poke(1'b1);
        chk_bit(in_deep_power_down, 1'b1);
        send(8'hA5, 4'h0);
        chk_num(wc, 12'h014);
        chk_num(ac, 12'h000);
        chk_bit(in_standby, 1'b1);
        poke(1'b1);
        send(8'hAB, 4'h1);
        chk_num(nb, 12'h001);
        chk_num(bad, 12'h000);
        chk_num(wc, 12'h014);
        $display("wake from power-down done");
        por_active <= 1'b1;
        send(8'h3C, 4'h0);
        por_active <= 1'b0;
        @(posedge clk);
        chk_bit(reset_armed, 1'b0);
        chk_bit(in_standby, 1'b1);
        $display("power-on reset done");
        poke(1'b0);
        rst <= 1'b1;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        chk_bit(write_enable_latch, 1'b0);
        chk_bit(in_standby, 1'b1);
        chk_bit(link_ready, 1'b0);
        $display("second reset done");
        give_verdict();
    end
endmodule // flash_power_state_reset_ctl_tb_top
